// file: usb_phy_ctrl_pkg.sv
// Package: register map, field layout and constants of the PHY control block
package usb_phy_ctrl_pkg;
   localparam logic [7:0]  CTRL_ADDR       = 8'h40;
   localparam logic [7:0]  STAT_ADDR       = 8'h44;
   localparam int          PULLDN_DIS_BIT  = 18;
   localparam int          RST_SEEN_BIT    = 13;
   localparam int          RES_SEEN_BIT    = 12;
   localparam int          FILT_LSB        = 8;
   localparam int          FILT_W          = 4;
   localparam int          AUTO_RES_BIT    = 7;
   localparam int          CONF_LSB        = 4;
   localparam int          CONF_W          = 3;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK      = 32'h0004_3ff0;
   localparam logic [1:0]  LS_SE0          = 2'h0;
   localparam logic [1:0]  LS_K            = 2'h2;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  HSIZE_WORD      = 3'h2;
   localparam int          FILT_CNT_W      = 16;
endpackage : usb_phy_ctrl_pkg

// file: usb_line_filter.sv
// Line-state debounce filter with a 2^N clock hold time
`timescale 1ns/100ps
module usb_line_filter #(
   parameter int LS_W  = 2,
   parameter int CNT_W = 16
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic [3:0]      log2_len,
   input  wire logic [LS_W-1:0] raw,
   output logic      [LS_W-1:0] filt
);
   logic [LS_W-1:0]  cand_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;

   // Counter must reach the longest period, 2^15 clocks
   if (CNT_W < 16) begin : g_cnt_chk
      $error("CNT_W must hold 2^15");
   end

   assign limit = CNT_W'((32'h1 << log2_len) - 32'h1);

   // New state passes only after holding for the full period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cand_q <= '0;
         cnt_q  <= '0;
         filt   <= '0;
      end else if (raw != cand_q) begin
         cand_q <= raw;
         cnt_q  <= '0;
      end else if (cand_q != filt) begin
         if (cnt_q >= limit) begin
            filt <= cand_q;
         end else begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end else begin
         cnt_q <= '0;
      end
   end

   a_filt_stable: assert property (
      @(posedge clk) disable iff (!rst_n)
      (filt != $past(filt)) |-> ($past(raw) == filt))
      else $error("filtered state changed without stable input");
endmodule : usb_line_filter

// file: usb_phy_control_resume.sv
// Top: PHY control register, line filter and auto-resume detection
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
module usb_phy_control_resume (
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   input  wire logic [1:0]  I_LINE_STATE,
   input  wire logic        I_SUSPENDED,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   output logic      [2:0]  O_PHY_CONFIG,
   output logic             O_PULLDN_EN_WIDE_PORT_A,
   output logic             O_PULLDN_EN_WIDE_PORT_B,
   output logic      [1:0]  O_LINE_STATE_FILT,
   output logic             O_RESUME_WAKE
);
   //------------------------------------------------
   // Reset synchroniser
   //------------------------------------------------
   logic rst_meta_q;
   logic rst_n;
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   //------------------------------------------------
   // Bus slave
   //------------------------------------------------
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [7:0]  addr_q;
   logic [31:0] ctrl_q;
   logic        sw_wr;
   logic        set_rst;
   logic        set_res;
   logic        addr_ok;
   logic        acc;
   logic [31:0] wdat;

   assign acc     = I_HSEL && I_HREADY &&
                    I_HTRANS == usb_phy_ctrl_pkg::HTRANS_NONSEQ;
   assign addr_ok = I_HADDR[31:8] == 24'h0;
   assign sw_wr   = wr_pend_q && addr_q == usb_phy_ctrl_pkg::CTRL_ADDR;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= acc && I_HWRITE;
         rd_pend_q <= acc && !I_HWRITE;
         addr_q    <= addr_ok ? I_HADDR[7:0] : 8'hff;
      end
   end

   // Zero-wait slave, always OKAY
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
         O_HRDATA    <= 32'h0000_0000;
      end else if (acc && !I_HWRITE && addr_ok) begin
         case (I_HADDR[7:0])
            // Forward a write still in its data phase
            usb_phy_ctrl_pkg::CTRL_ADDR:
               O_HRDATA <= sw_wr ? wdat : ctrl_q;
            usb_phy_ctrl_pkg::STAT_ADDR:
               O_HRDATA <= {30'h0, O_LINE_STATE_FILT};
            default: O_HRDATA <= 32'h0000_0000;
         endcase
      end else if (acc) begin
         O_HRDATA <= 32'h0000_0000;
      end
   end

   //------------------------------------------------
   // Control register
   //------------------------------------------------
   assign wdat = I_HWDATA & usb_phy_ctrl_pkg::CTRL_WMASK;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= usb_phy_ctrl_pkg::CTRL_RESET;
      end else begin
         if (sw_wr) begin
            ctrl_q <= wdat;
         end
         // Hardware set wins over software clear
         if (set_rst) begin
            ctrl_q[usb_phy_ctrl_pkg::RST_SEEN_BIT] <= 1'b1;
         end
         if (set_res) begin
            ctrl_q[usb_phy_ctrl_pkg::RES_SEEN_BIT] <= 1'b1;
         end
      end
   end

   //------------------------------------------------
   // PHY side outputs
   //------------------------------------------------
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_PHY_CONFIG            <= 3'h0;
         O_PULLDN_EN_WIDE_PORT_A <= 1'b1;
         O_PULLDN_EN_WIDE_PORT_B <= 1'b1;
      end else begin
         O_PHY_CONFIG <= ctrl_q[usb_phy_ctrl_pkg::CONF_LSB +:
                                usb_phy_ctrl_pkg::CONF_W];
         O_PULLDN_EN_WIDE_PORT_A <=
            !ctrl_q[usb_phy_ctrl_pkg::PULLDN_DIS_BIT];
         O_PULLDN_EN_WIDE_PORT_B <=
            !ctrl_q[usb_phy_ctrl_pkg::PULLDN_DIS_BIT];
      end
   end

   //------------------------------------------------
   // Line filter and auto-resume
   //------------------------------------------------
   logic [1:0] filt;
   logic       susp_q;
   logic       auto_en;

   usb_line_filter #(
      .LS_W  (2),
      .CNT_W (usb_phy_ctrl_pkg::FILT_CNT_W)
   ) u_filt (
      .clk      (I_CLK),
      .rst_n    (rst_n),
      .log2_len (ctrl_q[usb_phy_ctrl_pkg::FILT_LSB +:
                        usb_phy_ctrl_pkg::FILT_W]),
      .raw      (I_LINE_STATE),
      .filt     (filt)
   );

   assign auto_en = ctrl_q[usb_phy_ctrl_pkg::AUTO_RES_BIT];
   // Wakeup seen while suspended: filtered state is SE0 (reset flag) or K (resume flag)
   assign set_rst = auto_en && susp_q && I_SUSPENDED &&
                    filt == usb_phy_ctrl_pkg::LS_SE0;
   assign set_res = auto_en && susp_q && I_SUSPENDED &&
                    filt == usb_phy_ctrl_pkg::LS_K;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         susp_q            <= 1'b0;
         O_LINE_STATE_FILT <= 2'h0;
         O_RESUME_WAKE     <= 1'b0;
      end else begin
         susp_q            <= I_SUSPENDED;
         O_LINE_STATE_FILT <= filt;
         O_RESUME_WAKE     <= set_rst || set_res;
      end
   end

   a_pd_follows: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      ##1 O_PULLDN_EN_WIDE_PORT_A ==
          !$past(ctrl_q[usb_phy_ctrl_pkg::PULLDN_DIS_BIT]))
      else $error("pulldown enable wrong");
   a_rst_flag: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      set_rst |=> ctrl_q[usb_phy_ctrl_pkg::RST_SEEN_BIT])
      else $error("reset flag not set");
   a_res_flag: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      set_res |=> ctrl_q[usb_phy_ctrl_pkg::RES_SEEN_BIT])
      else $error("resume flag not set");
   a_flag_sticky: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      ctrl_q[usb_phy_ctrl_pkg::RES_SEEN_BIT] && !sw_wr
      |=> ctrl_q[usb_phy_ctrl_pkg::RES_SEEN_BIT])
      else $error("resume flag dropped");
   a_rst_sticky: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      ctrl_q[usb_phy_ctrl_pkg::RST_SEEN_BIT] && !sw_wr
      |=> ctrl_q[usb_phy_ctrl_pkg::RST_SEEN_BIT])
      else $error("reset flag dropped");
   a_no_auto: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      !auto_en |=> !O_RESUME_WAKE)
      else $error("wake without auto resume");
   a_conf_out: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      ##1 O_PHY_CONFIG == $past(ctrl_q[usb_phy_ctrl_pkg::CONF_LSB +:
                                       usb_phy_ctrl_pkg::CONF_W]))
      else $error("config pins mismatch");
   // Period 4: new state sampled on five edges before it passes
   a_filt_hold: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      $past(ctrl_q[usb_phy_ctrl_pkg::FILT_LSB +: usb_phy_ctrl_pkg::FILT_W])
         == 4'h2 && filt != $past(filt)
      |-> $past(I_LINE_STATE, 1) == filt && $past(I_LINE_STATE, 2) == filt
          && $past(I_LINE_STATE, 3) == filt && $past(I_LINE_STATE, 4) == filt
          && $past(I_LINE_STATE, 5) == filt)
      else $error("filter passed too early");
   a_filt_revert: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      (I_LINE_STATE == filt) [*2] |=> filt == $past(filt))
      else $error("filter changed without input");
endmodule : usb_phy_control_resume

// file: usb_phy_model.sv
// Behavioural model of the on-chip USB PHY line side
`timescale 1ns/100ps
module usb_phy_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_bus_state,
   input  wire logic       i_pulldn_en_a,
   input  wire logic       i_pulldn_en_b,
   output logic      [1:0] o_line_state,
   output logic            o_pulled_down
);
   // Receiver reports the bus one clock late
   always_ff @(posedge i_clk) begin
      o_line_state <= i_bus_state;
   end
   assign o_pulled_down = i_pulldn_en_a | i_pulldn_en_b;
endmodule : usb_phy_model

// file: usb_phy_control_resume_tb.sv
// Self-checking bench of the USB PHY control block
`timescale 1ns/100ps
module usb_phy_control_resume_tb;
   localparam logic [7:0] CTL = usb_phy_ctrl_pkg::CTRL_ADDR;
   localparam logic [7:0] STA = usb_phy_ctrl_pkg::STAT_ADDR;
   logic        clk    = 1'b0;
   logic        rst_n  = 1'b0;
   logic [31:0] haddr  = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  bus    = 2'h1;
   logic        susp   = 1'b0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic [2:0]  cfg;
   logic        pd_a;
   logic        pd_b;
   logic        pd;
   logic [1:0]  ls;
   logic [1:0]  filt;
   logic        wake;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          checks    = 0;
   always #2.5 clk = ~clk;
   usb_phy_control_resume dut (.I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(1'b1),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(usb_phy_ctrl_pkg::HSIZE_WORD), .I_HWDATA(hwdata),
      .I_HREADY(hready), .I_LINE_STATE(ls), .I_SUSPENDED(susp),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .O_PHY_CONFIG(cfg), .O_PULLDN_EN_WIDE_PORT_A(pd_a),
      .O_PULLDN_EN_WIDE_PORT_B(pd_b), .O_LINE_STATE_FILT(filt),
      .O_RESUME_WAKE(wake));
   usb_phy_model phy (.i_clk(clk), .i_bus_state(bus), .i_pulldn_en_a(pd_a),
      .i_pulldn_en_b(pd_b), .o_line_state(ls), .o_pulled_down(pd));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= usb_phy_ctrl_pkg::HTRANS_NONSEQ;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask : xfer
   task automatic hold(input logic [1:0] s, input int n, input logic [1:0] e);
      bus <= s;
      repeat (n) begin
         @(posedge clk);
         #1 cmp({30'h0, filt}, {30'h0, e});
      end
   endtask : hold
   task automatic t_reset;
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, usb_phy_ctrl_pkg::CTRL_RESET);
      cmp({29'h0, pd, pd_a, pd_b}, 32'h7);
      cmp({29'h0, cfg}, 32'h0);
      cmp({30'h0, hready, hresp}, 32'h2);
   endtask : t_reset
   task automatic t_config;
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, CTL, 32'(i) << usb_phy_ctrl_pkg::CONF_LSB);
         @(posedge clk);
         #1 cmp({29'h0, cfg}, 32'(i));
      end
      xfer(1'b1, CTL, 32'h1 << usb_phy_ctrl_pkg::PULLDN_DIS_BIT);
      @(posedge clk);
      #1 cmp({29'h0, pd, pd_a, pd_b}, 32'h0);
      xfer(1'b1, CTL, 32'hffff_ffff);
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, usb_phy_ctrl_pkg::CTRL_WMASK);
      xfer(1'b0, 8'h80, 32'h0);
      cmp(rd, 32'h0);
      xfer(1'b1, CTL, 32'h0);
      @(posedge clk);
      #1 cmp({29'h0, pd, pd_a, pd_b}, 32'h7);
   endtask : t_config
   task automatic t_filter;
      xfer(1'b1, CTL, 32'h2 << usb_phy_ctrl_pkg::FILT_LSB);
      hold(2'h1, 12, 2'h1);
      hold(2'h2, 3, 2'h1);
      hold(2'h1, 1, 2'h1);
      hold(2'h2, 3, 2'h1);
      hold(2'h1, 8, 2'h1);
      @(posedge clk);
      susp <= 1'b1;
      hold(2'h2, 3, 2'h1);
      repeat (6) @(posedge clk);
      #1 cmp({30'h0, filt}, {30'h0, usb_phy_ctrl_pkg::LS_K});
      cmp({31'h0, wake}, 32'h0);
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, 32'h0000_0200);
      xfer(1'b0, STA, 32'h0);
      cmp(rd, {30'h0, usb_phy_ctrl_pkg::LS_K});
   endtask : t_filter
   task automatic t_auto(input logic [1:0] s, input logic [31:0] f);
      @(posedge clk);
      susp <= 1'b1;
      bus  <= s;
      xfer(1'b1, CTL, 32'h80);
      repeat (8) @(posedge clk);
      #1 cmp({31'h0, wake}, 32'h1);
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, 32'h80 | f);
      @(posedge clk);
      susp <= 1'b0;
      bus  <= 2'h1;
      repeat (8) @(posedge clk);
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, 32'h80 | f);
      xfer(1'b1, CTL, 32'h80);
      xfer(1'b0, CTL, 32'h0);
      cmp(rd, 32'h80);
   endtask : t_auto
   task automatic complete_run;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_config;
      t_filter;
      t_auto(usb_phy_ctrl_pkg::LS_K, 32'h1000);
      t_auto(usb_phy_ctrl_pkg::LS_SE0, 32'h2000);
      complete_run;
   end
   initial begin
      #20us;
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run;
   end
endmodule : usb_phy_control_resume_tb
